// ===== dpr_pkg.sv
// shared constants and carrier types for the dual port register select block
package dpr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // shared (single copy) register offsets
    localparam logic [7:0] REG_LANE_CFG = 8'h00;
    localparam logic [7:0] REG_PORT_SEL = 8'h01;
    localparam logic [7:0] REG_BC_GPIO = 8'h02;
    localparam logic [7:0] REG_BC_I2C = 8'h03;
    // duplicated (per port) register window
    localparam logic [7:0] REG_DUP_BASE = 8'h10;
    localparam int DUP_COUNT = 4;

    // field positions
    localparam int LANE_DUAL_BIT = 0;
    localparam int FIRST_SEL_BIT = 0;
    localparam int SECOND_SEL_BIT = 1;
    localparam int SECOND_ADDR_EN_BIT = 7;
    localparam int BC_CRC_ERR_BIT = 7;

    // reset values
    localparam logic [7:0] LANE_CFG_RST = 8'h00;
    localparam logic [7:0] PORT_SEL_RST = 8'h00;
    localparam logic [7:0] DUP_RST = 8'h00;

    // per-port write masks
    localparam logic [1:0] PORT0_MASK = 2'b01;
    localparam logic [1:0] PORT1_MASK = 2'b10;
    localparam logic [1:0] NO_PORT = 2'b00;

    // forward symbol layout
    localparam int SYM_W = 35;
    localparam int PAY_W = 33;
    localparam int LFSR_W = 16;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    localparam logic CLK_MARK = 1'b1;

    // back channel frame check
    localparam int BC_CRC_W = 4;
    localparam logic [3:0] BC_CRC_POLY = 4'h3;
    localparam logic [3:0] BC_CRC_INIT = 4'hF;

    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic write;
        logic second_addr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dpr_req_t;

    typedef struct packed {
        logic [23:0] colour;
        logic hs;
        logic vs;
        logic de;
        logic ctrl_bit;
        logic [3:0] gpio;
        logic audio;
    } dpr_video_t;

    typedef struct packed {
        logic [7:0] i2c_data;
        logic [3:0] gpio;
        logic [3:0] crc;
    } dpr_bc_frame_t;

endpackage : dpr_pkg

// ===== dpr_dual_port_regs.sv
// port-steered register bank with forward symbol and back channel paths
// Functional notes
// - single select bit picks that port's copy
// - both select bits set: read port1 copy
// - writes hit every selected port copy
// - shared registers ignore the select bits
// - second address enable answers and reaches port1
// - second address enable overrides both select bits
// - one 35-bit symbol each pixel clock
// - pixel clock range depends on lane mode
// - lane rate never below minimum per lane
// - embedded clock, DC-balanced payload for AC coupling
// - 33 bits carry video, control, gpio, audio, scrambled
// - control channel rides forward and reverse paths
// - bridged traffic joins normal bus arbitration
// - back channel arrives as serial frames
// - frames carry i2c data, CRC, four gpio
// - local host programs device through slave port
// - power-down low resets every control register
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module dpr_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : dpr_sync2

////////////////////////////////////////////////////////////////////////////
module dpr_afifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic wclk,
    input wire logic wrst_b,
    input wire logic w_valid,
    input wire logic [W-1:0] w_data,
    output logic w_ready,
    input wire logic rclk,
    input wire logic rrst_b,
    output logic r_valid,
    output logic [W-1:0] r_data,
    input wire logic r_ready
);
    localparam int A = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [A:0] wbin_q, wgray_q, rbin_q, rgray_q, rgray_w, wgray_r;
    logic [A:0] wbin_d, rbin_d;

    // gray pointers cross; binary pointers never leave their domain
    dpr_sync2 #(.W(A+1)) u_r2w (
        .clk(wclk), .rst_b(wrst_b), .d(rgray_q), .q(rgray_w));
    dpr_sync2 #(.W(A+1)) u_w2r (
        .clk(rclk), .rst_b(rrst_b), .d(wgray_q), .q(wgray_r));

    assign w_ready = (wgray_q != {~rgray_w[A:A-1], rgray_w[A-2:0]});
    assign r_valid = (rgray_q != wgray_r);
    assign r_data = mem[rbin_q[A-1:0]];
    assign wbin_d = wbin_q + (A+1)'(w_valid && w_ready);
    assign rbin_d = rbin_q + (A+1)'(r_valid && r_ready);

    always_ff @(posedge wclk) begin
        if (w_valid && w_ready) begin
            mem[wbin_q[A-1:0]] <= w_data;
        end
    end

    always_ff @(posedge wclk) begin
        if (!wrst_b) begin
            wbin_q <= '0;
            wgray_q <= '0;
        end else begin
            wbin_q <= wbin_d;
            wgray_q <= wbin_d ^ (wbin_d >> 1);
        end
    end

    always_ff @(posedge rclk) begin
        if (!rrst_b) begin
            rbin_q <= '0;
            rgray_q <= '0;
        end else begin
            rbin_q <= rbin_d;
            rgray_q <= rbin_d ^ (rbin_d >> 1);
        end
    end
endmodule : dpr_afifo

////////////////////////////////////////////////////////////////////////////
module dpr_dual_port_regs #(
    parameter int NDUP = dpr_pkg::DUP_COUNT,
    parameter int DEPTH = dpr_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic power_down_input_b,
    input wire logic acc_valid,
    input wire dpr_pkg::dpr_req_t acc_req,
    output logic acc_ack,
    output logic [dpr_pkg::DATA_W-1:0] acc_rdata,
    input wire logic video_valid,
    input wire dpr_pkg::dpr_video_t video_in,
    output logic video_ready,
    input wire logic link_ready,
    output logic sym_valid0,
    output logic [dpr_pkg::SYM_W-1:0] sym_lane0,
    output logic sym_valid1,
    output logic [dpr_pkg::SYM_W-1:0] sym_lane1,
    input wire logic bc_valid,
    input wire dpr_pkg::dpr_bc_frame_t bc_frame
);
    import dpr_pkg::*;

    function automatic logic [3:0] crc4(input logic [11:0] bits);
        logic [3:0] c;
        c = BC_CRC_INIT;
        for (int i = 11; i >= 0; i--) begin
            c = {c[2:0], 1'b0} ^ ((c[3] ^ bits[i]) ? BC_CRC_POLY : 4'h0);
        end
        return c;
    endfunction : crc4

    function automatic logic heavy(input logic [PAY_W-1:0] v);
        int n;
        n = 0;
        for (int i = 0; i < PAY_W; i++) begin
            n = n + int'(v[i]);
        end
        return n > PAY_W / 2;
    endfunction : heavy

    ////////////////////////////////////////////////////////////////////////
    // power-down pin and reset into both domains
    logic pdb_s;
    logic ctl_rst_b;
    logic link_rst_b;

    dpr_sync2 #(.W(1)) u_pdb (
        .clk(clk), .rst_b(rst_b), .d(power_down_input_b), .q(pdb_s));

    assign ctl_rst_b = rst_b && pdb_s;

    // reset release into the pixel clock domain is a level crossing
    dpr_sync2 #(.W(1)) u_lrst (
        .clk(link_clk), .rst_b(1'b1), .d(ctl_rst_b), .q(link_rst_b));

    ////////////////////////////////////////////////////////////////////////
    // register bank
    logic [DATA_W-1:0] lane_cfg_q;
    logic [DATA_W-1:0] port_sel_q;
    logic [DATA_W-1:0] dup_q [2][NDUP];
    logic [DATA_W-1:0] bc_gpio_q;
    logic [DATA_W-1:0] bc_i2c_q;
    logic first_sel, second_sel, second_en;
    logic is_dup, is_shared, respond;
    logic [ADDR_W-1:0] dup_idx;
    logic [1:0] wr_mask;
    logic rd_port;
    logic [DATA_W-1:0] rd_d;

    assign first_sel = port_sel_q[FIRST_SEL_BIT];
    assign second_sel = port_sel_q[SECOND_SEL_BIT];
    assign second_en = port_sel_q[SECOND_ADDR_EN_BIT];
    assign dup_idx = acc_req.addr - REG_DUP_BASE;
    assign is_dup = (acc_req.addr >= REG_DUP_BASE)
        && (dup_idx < ADDR_W'(NDUP));
    // shared registers need no port steering
    assign is_shared = !is_dup;
    // second address only answered while enabled
    assign respond = acc_valid && (!acc_req.second_addr || second_en);

    always_comb begin
        if (second_en) begin
            // address picks the port, select bits ignored
            wr_mask = acc_req.second_addr ? PORT1_MASK : PORT0_MASK;
            rd_port = acc_req.second_addr;
        end else if (!first_sel && !second_sel) begin
            // nothing selected falls back to port0
            wr_mask = PORT0_MASK;
            rd_port = 1'b0;
        end else begin
            wr_mask = {second_sel, first_sel};
            // single select; both set reads port1
            rd_port = second_sel;
        end
    end

    always_comb begin
        rd_d = '0;
        if (is_dup) begin
            rd_d = dup_q[rd_port][dup_idx[$clog2(NDUP)-1:0]];
        end else begin
            unique case (acc_req.addr)
                REG_LANE_CFG: rd_d = lane_cfg_q;
                REG_PORT_SEL: rd_d = port_sel_q;
                REG_BC_GPIO: rd_d = bc_gpio_q;
                REG_BC_I2C: rd_d = bc_i2c_q;
                default: rd_d = '0;
            endcase
        end
    end

    // requests come in already won on the host bus
    always_ff @(posedge clk) begin
        if (!ctl_rst_b) begin
            acc_ack <= 1'b0;
            acc_rdata <= '0;
        end else begin
            acc_ack <= respond;
            acc_rdata <= (respond && !acc_req.write) ? rd_d : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!ctl_rst_b) begin
            lane_cfg_q <= LANE_CFG_RST;
            port_sel_q <= PORT_SEL_RST;
        end else if (respond && acc_req.write && is_shared) begin
            if (acc_req.addr == REG_LANE_CFG) begin
                lane_cfg_q <= acc_req.wdata;
            end
            if (acc_req.addr == REG_PORT_SEL) begin
                port_sel_q <= acc_req.wdata;
            end
        end
    end

    // copies picked by wr_mask written in one access; both only when both select bits set
    always_ff @(posedge clk) begin
        if (!ctl_rst_b) begin
            for (int p = 0; p < 2; p++) begin
                for (int i = 0; i < NDUP; i++) begin
                    dup_q[p][i] <= DUP_RST;
                end
            end
        end else if (respond && acc_req.write && is_dup) begin
            for (int p = 0; p < 2; p++) begin
                if (wr_mask[p]) begin
                    dup_q[p][dup_idx[$clog2(NDUP)-1:0]] <= acc_req.wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // forward path: video words cross into the pixel clock domain
    logic fifo_valid;
    dpr_video_t fifo_word;
    logic dual_l;

    dpr_afifo #(.W($bits(dpr_video_t)), .DEPTH(DEPTH)) u_fifo (
        .wclk(clk),
        .wrst_b(ctl_rst_b),
        .w_valid(video_valid),
        .w_data(video_in),
        .w_ready(video_ready),
        .rclk(link_clk),
        .rrst_b(link_rst_b),
        .r_valid(fifo_valid),
        .r_data(fifo_word),
        .r_ready(link_ready)
    );

    // lane mode chosen by software to suit the pixel clock
    dpr_sync2 #(.W(1)) u_dual (
        .clk(link_clk), .rst_b(link_rst_b),
        .d(lane_cfg_q[LANE_DUAL_BIT]), .q(dual_l));

    localparam int DISP_W = $clog2(PAY_W) + 3;
    logic [LFSR_W-1:0] lfsr_q;
    logic signed [DISP_W-1:0] disp_q;
    logic rd_pos;
    logic lane_sel_q;
    logic take;
    logic [PAY_W-1:0] scr;
    logic inv;
    logic [SYM_W-1:0] sym;

    assign take = fifo_valid && link_ready;
    // video, sync, control bit, gpio and audio, scrambled
    assign scr = fifo_word ^ {lfsr_q, lfsr_q, lfsr_q[0]};
    // invert when it would grow the running disparity
    assign rd_pos = disp_q > 0;
    assign inv = (heavy(scr) == rd_pos);
    // one 35-bit symbol with embedded clock mark
    assign sym = {CLK_MARK, inv, inv ? ~scr : scr};

    // lfsr steps only on sent symbols so the far end stays aligned
    always_ff @(posedge link_clk) begin
        if (!link_rst_b) begin
            lfsr_q <= LFSR_SEED;
        end else if (take) begin
            lfsr_q <= {lfsr_q[LFSR_W-2:0], ^(lfsr_q & LFSR_TAPS)};
        end
    end

    // running disparity of sent symbols; a sign bit alone lets it drift
    always_ff @(posedge link_clk) begin
        if (!link_rst_b) begin
            disp_q <= '0;
        end else if (take) begin
            disp_q <= disp_q + DISP_W'(2 * $countones(sym[PAY_W-1:0]))
                - DISP_W'(PAY_W);
        end
    end

    // dual mode halves each lane's share, not its line rate
    always_ff @(posedge link_clk) begin
        if (!link_rst_b) begin
            lane_sel_q <= 1'b0;
            sym_valid0 <= 1'b0;
            sym_valid1 <= 1'b0;
            sym_lane0 <= '0;
            sym_lane1 <= '0;
        end else begin
            sym_valid0 <= take && !(dual_l && lane_sel_q);
            sym_valid1 <= take && dual_l && lane_sel_q;
            if (take) begin
                lane_sel_q <= dual_l ? !lane_sel_q : 1'b0;
                if (dual_l && lane_sel_q) begin
                    sym_lane1 <= sym;
                end else begin
                    sym_lane0 <= sym;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // back channel frames, checked in the pixel domain, handed over
    // by toggle; a frame arriving within three clk cycles of the last
    // one may be seen mixed, which the slow frame rate never allows
    dpr_bc_frame_t bc_hold_q;
    logic bc_err_l_q;
    logic bc_tgl_q;
    logic bc_tgl_s, bc_tgl_seen_q;

    // serial frames from the far end
    always_ff @(posedge link_clk) begin
        if (!link_rst_b) begin
            bc_hold_q <= '0;
            bc_err_l_q <= 1'b0;
            bc_tgl_q <= 1'b0;
        end else if (bc_valid) begin
            // i2c byte, four gpio, crc checked
            bc_hold_q <= bc_frame;
            bc_err_l_q <= crc4({bc_frame.i2c_data, bc_frame.gpio})
                != bc_frame.crc;
            bc_tgl_q <= !bc_tgl_q;
        end
    end

    dpr_sync2 #(.W(1)) u_bctgl (
        .clk(clk), .rst_b(ctl_rst_b), .d(bc_tgl_q), .q(bc_tgl_s));

    // reverse control data lands in host-visible registers
    always_ff @(posedge clk) begin
        if (!ctl_rst_b) begin
            bc_tgl_seen_q <= 1'b0;
            bc_gpio_q <= '0;
            bc_i2c_q <= '0;
        end else begin
            bc_tgl_seen_q <= bc_tgl_s;
            if (bc_tgl_s != bc_tgl_seen_q) begin
                bc_gpio_q <= {bc_err_l_q, 3'b000, bc_hold_q.gpio};
                bc_i2c_q <= bc_hold_q.i2c_data;
            end
        end
    end

endmodule : dpr_dual_port_regs

// ===== dpr_chk_asserts.sv
// concurrent checks on the port steered register bank
`timescale 1ns/1ps
module dpr_chk #(
    parameter int NDUP = 4,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic power_down_input_b,
    input wire logic acc_valid,
    input wire dpr_pkg::dpr_req_t acc_req,
    input wire logic acc_ack,
    input wire logic [dpr_pkg::DATA_W-1:0] acc_rdata,
    input wire logic video_valid,
    input wire logic video_ready,
    input wire logic sym_valid0,
    input wire logic [dpr_pkg::SYM_W-1:0] sym_lane0,
    input wire logic sym_valid1,
    input wire logic [dpr_pkg::SYM_W-1:0] sym_lane1
);
    import dpr_pkg::*;
    logic [7:0] sel_q;
    logic [7:0] lane_q;
    logic take;
    logic rd_lane;
    int disp_q;
    assign take = acc_valid &&
        (!acc_req.second_addr || sel_q[SECOND_ADDR_EN_BIT]);
    assign rd_lane = take && !acc_req.write && !acc_req.second_addr &&
        acc_req.addr == REG_LANE_CFG;
    // shadow of shared registers; only primary-address writes reach it
    always_ff @(posedge clk) begin
        if (!rst_b || !power_down_input_b) begin
            sel_q <= 8'h00;
            lane_q <= 8'h00;
        end else if (take && acc_req.write && !acc_req.second_addr) begin
            if (acc_req.addr == REG_PORT_SEL) sel_q <= acc_req.wdata;
            if (acc_req.addr == REG_LANE_CFG) lane_q <= acc_req.wdata;
        end
    end
    // balance is judged on both lanes together since they share the stream
    always_ff @(posedge link_clk) begin
        if (!rst_b) disp_q <= 0;
        else disp_q <= disp_q
            + (sym_valid0 ? 2 * $countones(sym_lane0[32:0]) - 33 : 0)
            + (sym_valid1 ? 2 * $countones(sym_lane1[32:0]) - 33 : 0);
    end
    property p_ack_taken;
        @(posedge clk) disable iff (!rst_b) take |=> acc_ack;
    endproperty
    a_ack_taken: assert property (p_ack_taken)
        else $error("accepted access not acknowledged");
    property p_ack_cause;
        @(posedge clk) disable iff (!rst_b) acc_ack |-> $past(take);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("acknowledge without accepted access");
    property p_rdata_idle;
        @(posedge clk) disable iff (!rst_b) !acc_ack |-> acc_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside a read answer");
    property p_wr_rdata;
        @(posedge clk) disable iff (!rst_b)
        take && acc_req.write |=> acc_rdata == 8'h00;
    endproperty
    a_wr_rdata: assert property (p_wr_rdata)
        else $error("write answered with data");
    property p_shared;
        @(posedge clk) disable iff (!rst_b)
        rd_lane |=> acc_ack && acc_rdata == $past(lane_q);
    endproperty
    a_shared: assert property (p_shared)
        else $error("shared register read back wrong");
    property p_mark;
        @(posedge link_clk) disable iff (!rst_b)
        sym_valid0 || sym_valid1 |->
            (sym_valid0 ? sym_lane0[34] : sym_lane1[34]) == CLK_MARK;
    endproperty
    a_mark: assert property (p_mark)
        else $error("symbol without clock mark");
    property p_one_lane;
        @(posedge link_clk) disable iff (!rst_b) sym_valid0 |-> !sym_valid1;
    endproperty
    a_one_lane: assert property (p_one_lane)
        else $error("two symbols in one pixel clock");
    property p_disp;
        @(posedge link_clk) disable iff (!rst_b) disp_q <= 66 && disp_q >= -66;
    endproperty
    a_disp: assert property (p_disp)
        else $error("running disparity out of bound");
    property p_vready;
        @(posedge clk) disable iff (!rst_b || !power_down_input_b)
        $fell(video_ready) |-> $past(video_valid);
    endproperty
    a_vready: assert property (p_vready)
        else $error("buffer went full without a push");
    c_refused: cover property (@(posedge clk)
        acc_valid && acc_req.second_addr && !sel_q[SECOND_ADDR_EN_BIT]);
    c_full: cover property (@(posedge clk) !video_ready);
    c_lane1: cover property (@(posedge link_clk) sym_valid1);
endmodule : dpr_chk
////////////////////////////////////////////////////////////////////////////
bind dpr_dual_port_regs dpr_chk #(.NDUP(NDUP), .DEPTH(DEPTH)) u_chk (
    .clk(clk), .rst_b(rst_b), .link_clk(link_clk),
    .power_down_input_b(power_down_input_b), .acc_valid(acc_valid),
    .acc_req(acc_req), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
    .video_valid(video_valid), .video_ready(video_ready),
    .sym_valid0(sym_valid0), .sym_lane0(sym_lane0),
    .sym_valid1(sym_valid1), .sym_lane1(sym_lane1));

// ===== dpr_far_model.sv
// far side model: symbol sink and back channel frame source
`timescale 1ns/1ps
module dpr_far_model (
    input wire logic link_clk,
    input wire logic sym_valid0,
    input wire logic [dpr_pkg::SYM_W-1:0] sym_lane0,
    input wire logic sym_valid1,
    input wire logic [dpr_pkg::SYM_W-1:0] sym_lane1,
    output logic link_ready,
    output logic bc_valid,
    output dpr_pkg::dpr_bc_frame_t bc_frame
);
    import dpr_pkg::*;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic [3:0] cnt_q = 4'h0;
    logic [35:0] q[$];
    initial begin
        link_ready = 1'b0;
        bc_valid = 1'b0;
        bc_frame = '0;
    end
    // slow mode drops ready on a short pattern to exercise stalls
    always @(negedge link_clk) begin
        cnt_q <= cnt_q + 4'h1;
        link_ready <= !stall && !(slow && cnt_q[1]);
    end
    always @(posedge link_clk) begin
        if (sym_valid0) q.push_back({1'b0, sym_lane0});
        if (sym_valid1) q.push_back({1'b1, sym_lane1});
    end
    task automatic send(input dpr_bc_frame_t f);
        @(negedge link_clk);
        bc_valid <= 1'b1;
        bc_frame <= f;
        @(negedge link_clk);
        bc_valid <= 1'b0;
        bc_frame <= ~f;
    endtask : send
endmodule : dpr_far_model

// ===== tb.sv
// self-checking bench for the port steered register bank
`timescale 1ns/1ps
module tb;
    import dpr_pkg::*;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    logic power_down_input_b = 1'b1;
    logic acc_valid = 1'b0;
    dpr_req_t acc_req = '0;
    logic acc_ack, video_ready, link_ready, sym_valid0, sym_valid1, bc_valid;
    logic [7:0] acc_rdata, rd, sel, lane, gpio_m, i2c_m;
    logic video_valid = 1'b0;
    dpr_video_t video_in = '0;
    logic [SYM_W-1:0] sym_lane0, sym_lane1;
    dpr_bc_frame_t bc_frame;
    int err_total = 0;
    int total_checks = 0;
    int n;
    logic ok, ak;
    logic [31:0] seed = 32'h0000_0039;
    logic [7:0] dup[2][4];
    logic [32:0] wq[$];
    logic [15:0] lf = LFSR_SEED;
    logic [7:0] codes[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h80, 8'h83};
    logic [7:0] odd[4] = '{8'h02, 8'h03, 8'h14, 8'h20};
    always #4 clk = ~clk;
    initial #1.3 forever #3 link_clk = ~link_clk;
    dpr_dual_port_regs i_dpr_dual_port_regs (.clk(clk), .rst_b(rst_b),
        .link_clk(link_clk), .power_down_input_b(power_down_input_b),
        .acc_valid(acc_valid), .acc_req(acc_req), .acc_ack(acc_ack),
        .acc_rdata(acc_rdata), .video_valid(video_valid),
        .video_in(video_in), .video_ready(video_ready),
        .link_ready(link_ready), .sym_valid0(sym_valid0),
        .sym_lane0(sym_lane0), .sym_valid1(sym_valid1),
        .sym_lane1(sym_lane1), .bc_valid(bc_valid), .bc_frame(bc_frame));
    dpr_far_model u_far (.link_clk(link_clk), .sym_valid0(sym_valid0),
        .sym_lane0(sym_lane0), .sym_valid1(sym_valid1),
        .sym_lane1(sym_lane1), .link_ready(link_ready),
        .bc_valid(bc_valid), .bc_frame(bc_frame));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string nm, input logic [35:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    // ports touched: enable steers by address, else select bits, none->port0
    function automatic logic [1:0] wmask(input logic sa);
        if (sel[SECOND_ADDR_EN_BIT]) return sa ? PORT1_MASK : PORT0_MASK;
        return (sel[1:0] == NO_PORT) ? PORT0_MASK : sel[1:0];
    endfunction : wmask
    task automatic op(input logic w, sa, input logic [7:0] a, d);
        logic [1:0] m;
        logic [7:0] ex;
        m = wmask(sa);
        ok = !(sa && !sel[SECOND_ADDR_EN_BIT]);
        case (a)
            REG_LANE_CFG: ex = lane;
            REG_PORT_SEL: ex = sel;
            REG_BC_GPIO: ex = gpio_m;
            REG_BC_I2C: ex = i2c_m;
            default: ex = (a[7:2] == 6'h04) ? dup[m[1]][a[1:0]] : 8'h00;
        endcase
        @(negedge clk);
        acc_valid = 1'b1;
        acc_req = {w, sa, a, d};
        @(negedge clk);
        chk("ack", acc_ack, ok);
        chk("rdata", acc_rdata, (ok && !w) ? ex : 8'h00);
        rd = acc_rdata;
        acc_valid = 1'b0;
        if (ok && w && a == REG_LANE_CFG) lane = d;
        if (ok && w && a == REG_PORT_SEL) sel = d;
        for (int p = 0; p < 2; p++)
            if (ok && w && m[p] && a[7:2] == 6'h04) dup[p][a[1:0]] = d;
    endtask : op
    task automatic sweep();
        for (int k = 0; k < 4; k++) op(0, 0, 8'(k), 8'h00);
        for (int k = 0; k < 4; k++) op(0, 0, REG_DUP_BASE + 8'(k), 8'h00);
    endtask : sweep
    task automatic video(input int cnt, input logic dual);
        logic [32:0] w;
        logic [35:0] s;
        logic pl;
        n = 0;
        ok = 1'b1;
        while (ok && n < cnt) begin
            w = 33'({rnd(), rnd()});
            @(negedge clk);
            ok = (video_ready === 1'b1);
            video_valid = ok;
            video_in = w;
            if (ok) wq.push_back(w);
            if (ok) n++;
        end
        @(negedge clk);
        video_valid = 1'b0;
        u_far.stall = 1'b0;
        for (int i = 0; u_far.q.size() < n; i++) begin
            @(negedge clk);
            if (i > 3000) err_total++;
            if (i > 3000) summarize();
        end
        for (int i = 0; i < n; i++) begin
            s = u_far.q.pop_front();
            w = s[33] ? ~s[32:0] : s[32:0];
            chk("symbol", w ^ {lf, lf, lf[0]}, wq.pop_front());
            chk("lane", s[35], (dual && i > 0) ? !pl : 1'b0);
            pl = s[35];
            lf = {lf[14:0], ^(lf & LFSR_TAPS)};
        end
    endtask : video
    initial begin
        dup = '{default: 8'h00};
        {sel, lane, gpio_m, i2c_m} = 32'h0000_0000;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (10) @(negedge clk);
        sweep();
        $display("reset values done");
        foreach (codes[i]) begin
            op(1, 0, REG_PORT_SEL, codes[i]);
            op(1, 0, REG_LANE_CFG, 8'(rnd()));
            op(0, 0, REG_LANE_CFG, 8'h00);
            for (int s = 0; s < 2; s++) begin
                op(1, s[0], REG_DUP_BASE + 8'(rnd() % 4), 8'(rnd()));
                for (int k = 0; k < 4; k++) begin
                    op(0, 0, REG_DUP_BASE + 8'(k), 8'h00);
                    op(0, 1, REG_DUP_BASE + 8'(k), 8'h00);
                end
            end
        end
        foreach (odd[i]) op(1, 0, odd[i], 8'hA5);
        foreach (odd[i]) op(0, 0, odd[i], 8'h00);
        $display("port steering done");
        for (int f = 0; f < 4; f++) begin
            logic [3:0] c;
            logic [11:0] b;
            b = 12'(rnd());
            c = BC_CRC_INIT;
            for (int k = 11; k >= 0; k--)
                c = {c[2:0], 1'b0} ^ ((c[3] ^ b[k]) ? BC_CRC_POLY : 4'h0);
            u_far.send({b, c ^ {3'b000, f == 3}});
            repeat (12) @(negedge clk);
            {i2c_m, gpio_m} = {b[11:4], f == 3, 3'b000, b[3:0]};
            op(0, 0, REG_BC_I2C, 8'h00);
            op(0, 0, REG_BC_GPIO, 8'h00);
            if (f == 3) chk("crc_err", rd[BC_CRC_ERR_BIT], 1'b1);
        end
        $display("back channel done");
        op(1, 0, REG_LANE_CFG, 8'h00);
        u_far.stall = 1'b1;
        u_far.slow = 1'b1;
        repeat (10) @(negedge clk);
        video(40, 1'b0);
        chk("fill", n, FIFO_DEPTH);
        op(1, 0, REG_LANE_CFG, 8'h01);
        repeat (10) @(negedge clk);
        video(6, 1'b1);
        $display("video path done");
        gpio_m = 8'h00;
        power_down_input_b = 1'b0;
        repeat (5) @(negedge clk);
        power_down_input_b = 1'b1;
        repeat (4) @(negedge clk);
        dup = '{default: 8'h00};
        {sel, lane, gpio_m, i2c_m} = 32'h0000_0000;
        sweep();
        op(1, 0, REG_PORT_SEL, 8'h02);
        sweep();
        $display("power down done");
        summarize();
    end
endmodule : tb
